// *** src/prw_watchdog.sv ***
// Program runaway watchdog top level
`timescale 1ns/100ps
`include "prw_regs.svh"
module prw_watchdog (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Instruction events from the core, one-cycle pulses
	input wire logic CYCLE_TICK,
	input wire logic REFRESH_SKIP_INSTR,
	input wire logic GUARD_DISABLE_INSTR,
	input wire logic OTHER_INSTR,
	input wire logic RAM_BACKUP_ENTRY,
	// Status to the core
	output logic SKIP_NEXT,
	output logic FIRST_UNDERFLOW_FLAG,
	output logic SECOND_UNDERFLOW_FLAG,
	output logic GUARD_ENABLE_FLAG,
	// Reset pin, open drain
	input wire logic RESET_PIN_IN,
	output logic RESET_PIN_OUT,
	output logic RESET_PIN_OE,
	output logic RESET_PIN_LOW_SEEN
);
	logic [`PRW_CNT_W-1:0] runaway_down_counter;
	logic underflow;
	logic reinit;
	logic pair_done;
	logic [`PRW_SYNC_W-1:0] pin_sync;
	prw_pkg::prw_pair_t pair_state;

	//--------------------------------------------------
	// Counter
	//--------------------------------------------------
	// back-up reloads counter
	assign reinit = RAM_BACKUP_ENTRY;

	prw_down_counter u_counter (
		.clk(MCLK),
		.rst(RESET),
		.tick(CYCLE_TICK),
		.reinit(reinit),
		.count(runaway_down_counter),
		.underflow(underflow)
	);

	//--------------------------------------------------
	// Disable pairing
	//--------------------------------------------------
	// disable then refresh
	assign pair_done = (pair_state == prw_pkg::PRW_ARMED) &&
		REFRESH_SKIP_INSTR && !GUARD_DISABLE_INSTR;

	always_ff @(posedge MCLK) begin
		if (RESET || RAM_BACKUP_ENTRY) begin
			pair_state <= prw_pkg::PRW_IDLE;
		end else if (GUARD_DISABLE_INSTR) begin
			pair_state <= prw_pkg::PRW_ARMED;
		end else if (REFRESH_SKIP_INSTR || OTHER_INSTR) begin
			pair_state <= prw_pkg::PRW_IDLE;
		end
	end

	// enable set on reset and back-up
	always_ff @(posedge MCLK) begin
		if (RESET || RAM_BACKUP_ENTRY) begin
			GUARD_ENABLE_FLAG <= 1'b1;
		end else if (pair_done) begin
			GUARD_ENABLE_FLAG <= 1'b0;
		end
	end

	//--------------------------------------------------
	// Underflow flags
	//--------------------------------------------------
	// set wins over refresh clear
	always_ff @(posedge MCLK) begin
		if (RESET || RAM_BACKUP_ENTRY) begin
			FIRST_UNDERFLOW_FLAG <= 1'b0;
		end else if (underflow) begin
			FIRST_UNDERFLOW_FLAG <= 1'b1;
		end else if (REFRESH_SKIP_INSTR) begin
			FIRST_UNDERFLOW_FLAG <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			SECOND_UNDERFLOW_FLAG <= 1'b0;
		end else if (underflow && FIRST_UNDERFLOW_FLAG &&
			GUARD_ENABLE_FLAG) begin
			SECOND_UNDERFLOW_FLAG <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			SKIP_NEXT <= 1'b0;
		end else begin
			SKIP_NEXT <= REFRESH_SKIP_INSTR && FIRST_UNDERFLOW_FLAG;
		end
	end

	//--------------------------------------------------
	// Reset pin
	//--------------------------------------------------
	// pull-down held until system reset
	assign RESET_PIN_OUT = 1'b0;
	assign RESET_PIN_OE = SECOND_UNDERFLOW_FLAG;

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			pin_sync <= `PRW_SYNC_INIT;
		end else begin
			pin_sync <= {pin_sync[`PRW_SYNC_W-2:0], RESET_PIN_IN};
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			RESET_PIN_LOW_SEEN <= 1'b0;
		end else if (pin_sync[`PRW_SYNC_B1] == pin_sync[`PRW_SYNC_B2]) begin
			RESET_PIN_LOW_SEEN <= !pin_sync[`PRW_SYNC_B2];
		end
	end

	//--------------------------------------------------
	// Checks
	//--------------------------------------------------
	reset_load_a: assert property (
		@(posedge MCLK)
		RESET |=> runaway_down_counter == `PRW_CNT_INIT &&
			GUARD_ENABLE_FLAG && !FIRST_UNDERFLOW_FLAG)
	else $error("reset did not load counter and flags");

	first_set_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		CYCLE_TICK && runaway_down_counter == `PRW_CNT_ZERO &&
			!RAM_BACKUP_ENTRY |=> FIRST_UNDERFLOW_FLAG &&
			runaway_down_counter == `PRW_CNT_INIT)
	else $error("underflow did not set first flag");

	second_set_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		underflow && FIRST_UNDERFLOW_FLAG && GUARD_ENABLE_FLAG
			|=> SECOND_UNDERFLOW_FLAG && RESET_PIN_OE)
	else $error("second underflow did not pull reset");

	second_cause_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		$rose(SECOND_UNDERFLOW_FLAG) |->
			$past(FIRST_UNDERFLOW_FLAG) && $past(underflow))
	else $error("second flag set without first flag");

	disabled_quiet_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		!GUARD_ENABLE_FLAG && !SECOND_UNDERFLOW_FLAG
			|=> !SECOND_UNDERFLOW_FLAG)
	else $error("reset raised while guard disabled");

	pair_clear_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		(GUARD_DISABLE_INSTR && !RAM_BACKUP_ENTRY) ##1
			(REFRESH_SKIP_INSTR && !GUARD_DISABLE_INSTR &&
			!RAM_BACKUP_ENTRY) |=> !GUARD_ENABLE_FLAG)
	else $error("disable pair did not clear enable");

	lone_disable_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		GUARD_DISABLE_INSTR ##1 (OTHER_INSTR && !REFRESH_SKIP_INSTR &&
			!GUARD_DISABLE_INSTR)
			##1 (REFRESH_SKIP_INSTR && !GUARD_DISABLE_INSTR)
			|=> GUARD_ENABLE_FLAG == $past(GUARD_ENABLE_FLAG, 3) ||
			$past(RAM_BACKUP_ENTRY, 3) ||
			$past(RAM_BACKUP_ENTRY, 2) || $past(RAM_BACKUP_ENTRY))
	else $error("lone disable stopped the guard");

	backup_init_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		RAM_BACKUP_ENTRY |=> GUARD_ENABLE_FLAG &&
			!FIRST_UNDERFLOW_FLAG &&
			runaway_down_counter == `PRW_CNT_INIT)
	else $error("back-up entry did not reinitialise");

	skip_flag_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		REFRESH_SKIP_INSTR |=>
			SKIP_NEXT == $past(FIRST_UNDERFLOW_FLAG))
	else $error("skip does not follow first flag");

	skip_off_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		REFRESH_SKIP_INSTR && FIRST_UNDERFLOW_FLAG &&
			!GUARD_ENABLE_FLAG && !underflow
			|=> SKIP_NEXT && !FIRST_UNDERFLOW_FLAG)
	else $error("skip lost while guard disabled");

	pin_drive_a: assert property (
		@(posedge MCLK) disable iff (RESET)
		SECOND_UNDERFLOW_FLAG |=> RESET_PIN_OE [*2])
	else $error("pull-down released before reset");
endmodule : prw_watchdog

// *** common/prw_regs.svh ***
// Constants for the program runaway watchdog
// Behaviour
// - After reset load 16-bit counter with all ones; decrement per instruction cycle.
// - Count pulse arriving while counter is zero is an underflow; sets first flag.
// - Underflow without refresh sets second flag and pulls reset pin low.
// - Reset function active whenever enable flag is one after reset.
// - Disable immediately followed by refresh clears enable flag, stops reset function.
// - Disable not immediately followed by refresh leaves watchdog running.
// - Enable flag set on system reset and on RAM back-up entry.
// - Refresh with first flag set clears it and skips next instruction.
// - Refresh skip works even when the reset function is disabled.
// - Watchdog reset turns on reset pin pull-down and resets whole system.
// - RAM back-up entry reinitialises first flag and counter.
`ifndef PRW_REGS_SVH
`define PRW_REGS_SVH
`define PRW_CNT_W 16
`define PRW_CNT_INIT 16'hFFFF
`define PRW_CNT_ZERO 16'h0000
`define PRW_CNT_ONE 16'h0001
`define PRW_SYNC_W 3
`define PRW_SYNC_INIT 3'h7
`define PRW_SYNC_B1 1
`define PRW_SYNC_B2 2
`endif

// *** common/prw_pkg.sv ***
// Types shared by the program runaway watchdog
package prw_pkg;
	// Tracks whether the previous instruction was a disable
	typedef enum logic {
		PRW_IDLE,
		PRW_ARMED
	} prw_pair_t;
endpackage : prw_pkg

// *** src/prw_down_counter.sv ***
// Sixteen-bit down-counter with underflow detect
`timescale 1ns/100ps
`include "prw_regs.svh"
module prw_down_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic tick,
	input wire logic reinit,
	// Status
	output logic [`PRW_CNT_W-1:0] count,
	output logic underflow
);
	//--------------------------------------------------
	// Counting
	//--------------------------------------------------
	// underflow on zero
	assign underflow = tick && (count == `PRW_CNT_ZERO);

	always_ff @(posedge clk) begin
		if (rst || reinit) begin
			count <= `PRW_CNT_INIT;
		end else if (tick) begin
			count <= count - `PRW_CNT_ONE;
		end
	end

	//--------------------------------------------------
	// Checks
	//--------------------------------------------------
	count_step_a: assert property (
		@(posedge clk) disable iff (rst)
		tick && !reinit |=> count == $past(count) - `PRW_CNT_ONE)
	else $error("counter did not step down by one");

	count_hold_a: assert property (
		@(posedge clk) disable iff (rst)
		!tick && !reinit |=> $stable(count))
	else $error("counter moved without a tick");
endmodule : prw_down_counter

// *** verification/prw_core_model.sv ***
// CPU core model issuing watchdog instruction pulses
`timescale 1ns/100ps
module prw_core_model (
	// Clock
	input wire logic clk,
	// Instruction pulses
	output logic cycle_tick,
	output logic refresh,
	output logic disable_i,
	output logic other,
	output logic backup
);
	initial begin
		cycle_tick = 1'b0;
		refresh = 1'b0;
		disable_i = 1'b0;
		other = 1'b0;
		backup = 1'b0;
	end
	task automatic exec(input int op, input logic tk);
		cycle_tick = tk;
		refresh = (op == 1);
		disable_i = (op == 2);
		other = (op == 3);
		backup = (op == 4);
		@(negedge clk);
	endtask : exec
endmodule : prw_core_model

// *** verification/prw_watchdog_test.sv ***
// Self-checking testbench for the program runaway watchdog
`timescale 1ns/100ps
module prw_watchdog_test;
	logic MCLK = 1'b0;
	logic RESET = 1'b1;
	logic tick, refresh, disable_i, other, backup, pin;
	logic skip, first, second, enable, pin_out, pin_oe, low_seen;
	int failures = 0;
	int comparisons = 0;
	always #2 MCLK = ~MCLK;
	// Open-drain reset pin with pull-up
	assign pin = pin_oe ? pin_out : 1'b1;
	prw_core_model core (.clk(MCLK), .cycle_tick(tick), .refresh(refresh),
		.disable_i(disable_i), .other(other), .backup(backup));
	prw_watchdog dut (.MCLK(MCLK), .RESET(RESET), .CYCLE_TICK(tick),
		.REFRESH_SKIP_INSTR(refresh), .GUARD_DISABLE_INSTR(disable_i),
		.OTHER_INSTR(other), .RAM_BACKUP_ENTRY(backup), .SKIP_NEXT(skip),
		.FIRST_UNDERFLOW_FLAG(first), .SECOND_UNDERFLOW_FLAG(second),
		.GUARD_ENABLE_FLAG(enable), .RESET_PIN_IN(pin),
		.RESET_PIN_OUT(pin_out), .RESET_PIN_OE(pin_oe),
		.RESET_PIN_LOW_SEEN(low_seen));
	//------------------------------------------
	// Helpers
	//------------------------------------------
	function automatic logic past(int ticks, int n);
		return (ticks >= n * 65536) ? 1'b1 : 1'b0;
	endfunction : past
	task automatic check(string name, logic exp, logic got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask : check
	task automatic run(int n);
		repeat (n) core.exec(($urandom % 8 == 0) ? 3 : 0, 1'b1);
	endtask : run
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	//------------------------------------------
	// Main sequence
	//------------------------------------------
	initial begin
		int i;
		void'($urandom(13667));
		repeat (5) @(negedge MCLK);
		RESET = 1'b0;
		check("enable", 1'b1, enable);
		check("first", 1'b0, first);
		check("pin_oe", 1'b0, pin_oe);
		core.exec(1, 1'b0);
		check("skip", 1'b0, skip);
		core.exec(2, $urandom % 2);
		core.exec(3, $urandom % 2);
		core.exec(1, $urandom % 2);
		check("enable", 1'b1, enable);
		core.exec(2, $urandom % 2);
		core.exec(1, $urandom % 2);
		check("enable", 1'b0, enable);
		core.exec(1, 1'b0);
		core.exec(4, 1'b0);
		check("enable", 1'b1, enable);
		check("first", 1'b0, first);
		run(65535);
		check("first", past(65535, 1), first);
		run(1);
		check("first", past(65536, 1), first);
		check("second", 1'b0, second);
		run(65534);
		core.exec(2, 1'b1);
		check("second", past(131071, 2), second);
		core.exec(1, 1'b1);
		check("second", past(131072, 2), second);
		check("first", 1'b1, first);
		check("enable", 1'b0, enable);
		check("skip", 1'b1, skip);
		check("pin", 1'b0, pin);
		for (i = 0; i < 8 && low_seen !== 1'b1; i++) core.exec(0, 1'b0);
		check("low_seen", 1'b1, low_seen);
		core.exec(2, 1'b0);
		core.exec(1, 1'b0);
		check("skip", 1'b1, skip);
		check("first", 1'b0, first);
		check("enable", 1'b0, enable);
		core.exec(0, 1'b0);
		check("skip", 1'b0, skip);
		RESET = 1'b1;
		core.exec(0, 1'b0);
		RESET = 1'b0;
		check("second", 1'b0, second);
		check("enable", 1'b1, enable);
		end_of_test();
	end
endmodule : prw_watchdog_test
